// ==== dlgdc_pkg.sv ====
// constants and types for the dpll gain and damping configuration bank
package dlgdc_pkg;
    // register addresses
    localparam logic [7:0] ADDR_AUX_GAIN_DAMPING = 8'h6a;
    localparam logic [7:0] ADDR_SYS_GAIN_DAMPING = 8'h6b;
    localparam logic [7:0] ADDR_AUX_PD_GAIN = 8'h6c;
    localparam logic [7:0] ADDR_SYS_PD_GAIN = 8'h6d;
    // reset values
    localparam logic [7:0] RST_GAIN_DAMPING = 8'h13;
    localparam logic [7:0] RST_PD_GAIN = 8'hc2;
    // writable bits, the rest read as zero
    localparam logic [7:0] MASK_GAIN_DAMPING = 8'h77;
    localparam logic [7:0] MASK_PD_GAIN = 8'hf7;
    // field positions
    localparam int DAMPING_CODE_LSB = 0;
    localparam int GA8K_LSB = 4;
    localparam int GA_LSB = 4;
    localparam int GD_LSB = 0;
    localparam int EN_BIT = 7;
    localparam int FIELD_W = 3;
    // damping codes
    localparam logic [2:0] DAMPING_CODE_CODE_1 = 3'h1;
    localparam logic [2:0] DAMPING_CODE_CODE_2 = 3'h2;
    localparam logic [2:0] DAMPING_CODE_CODE_3 = 3'h3;
    localparam logic [2:0] DAMPING_CODE_CODE_4 = 3'h4;
    localparam logic [2:0] DAMPING_CODE_CODE_5 = 3'h5;
    // system bandwidth codes
    localparam logic [4:0] SYS_BW_4HZ = 5'h0d;
    localparam logic [4:0] SYS_BW_8HZ = 5'h0e;
    localparam logic [4:0] SYS_BW_18HZ = 5'h0f;
    localparam logic [4:0] SYS_BW_35HZ = 5'h10;
    localparam logic [4:0] SYS_BW_70HZ = 5'h11;
    // auxiliary bandwidth codes
    localparam logic [1:0] AUX_BW_18HZ = 2'h0;
    localparam logic [1:0] AUX_BW_35HZ = 2'h1;
    localparam logic [1:0] AUX_BW_70HZ = 2'h2;
    // system output frequency codes that set the feedback mode
    localparam logic [2:0] SYS_FREQ_DIGITAL = 3'h0;
    localparam logic [2:0] SYS_FREQ_ANALOG = 3'h1;
    localparam logic [2:0] GAIN_OFF = 3'h0;

    typedef enum logic [2:0] {
        DF_1P2 = 3'h0,
        DF_2P5 = 3'h1,
        DF_5 = 3'h2,
        DF_10 = 3'h3,
        DF_20 = 3'h4
    } dlgdc_df_t;

    typedef enum logic [2:0] {
        BW_LE4 = 3'h0,
        BW_8 = 3'h1,
        BW_18 = 3'h2,
        BW_35 = 3'h3,
        BW_70 = 3'h4
    } dlgdc_bw_t;
endpackage

// ==== dlgdc_path_if.sv ====
// per-path bundle between the register bank and its lookup modules
`timescale 1ns/1ps
interface dlgdc_path_if;
    import dlgdc_pkg::*;
    logic [2:0] damping_code_code;
    dlgdc_bw_t bw;
    logic pd2_en;
    logic analog;
    logic lowrate;
    logic [2:0] ga8k;
    logic [2:0] ga;
    logic [2:0] gd;
    dlgdc_df_t damping_code;
    logic [2:0] gain;
    logic active;
    modport bank (output damping_code_code, bw, pd2_en, analog, lowrate, ga8k, ga,
        gd, input damping_code, gain, active);
    modport dmp (input damping_code_code, bw, output damping_code);
    modport gan (input pd2_en, analog, lowrate, ga8k, ga, gd,
        output gain, active);
endinterface

// ==== dlgdc_damping.sv ====
// damping factor lookup from code and bandwidth column
`timescale 1ns/1ps
module dlgdc_damping
    import dlgdc_pkg::*;
(
    // path bundle
    dlgdc_path_if.dmp p
);
    always_comb begin
        case (p.damping_code_code)
            DAMPING_CODE_CODE_1: begin
                case (p.bw)
                    BW_LE4: p.damping_code = DF_5;
                    BW_8: p.damping_code = DF_2P5;
                    default: p.damping_code = DF_1P2;
                endcase
            end
            DAMPING_CODE_CODE_2: begin
                if (p.bw == BW_LE4 || p.bw == BW_8) begin
                    p.damping_code = DF_5;
                end else begin
                    p.damping_code = DF_2P5;
                end
            end
            DAMPING_CODE_CODE_4: begin
                if (p.bw == BW_35 || p.bw == BW_70) begin
                    p.damping_code = DF_10;
                end else begin
                    p.damping_code = DF_5;
                end
            end
            DAMPING_CODE_CODE_5: begin
                case (p.bw)
                    BW_35: p.damping_code = DF_10;
                    BW_70: p.damping_code = DF_20;
                    default: p.damping_code = DF_5;
                endcase
            end
            default: p.damping_code = DF_5;
        endcase
    end
endmodule

// ==== dlgdc_gain.sv ====
// phase detector 2 gain selection from feedback mode and input rate
`timescale 1ns/1ps
module dlgdc_gain
    import dlgdc_pkg::*;
(
    // path bundle
    dlgdc_path_if.gan p
);
    always_comb begin
        p.active = p.pd2_en;
        if (!p.pd2_en) begin
            p.gain = GAIN_OFF;
        end else if (!p.analog) begin
            p.gain = p.gd;
        end else if (p.lowrate) begin
            p.gain = p.ga8k;
        end else begin
            p.gain = p.ga;
        end
    end
endmodule

// ==== dlgdc_bank.sv ====
// gain and damping register bank for the system and auxiliary dplls
`timescale 1ns/1ps
module dlgdc_bank
    import dlgdc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // processor register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // loop settings from other registers
    input wire logic [1:0] aux_loop_bandwidth,
    input wire logic [4:0] system_acquire_bandwidth,
    input wire logic [4:0] system_locked_bandwidth,
    input wire logic system_acquire_active,
    input wire logic [2:0] system_output_freq_select,
    input wire logic aux_digital_feedback_select,
    input wire logic system_input_lowrate,
    input wire logic aux_input_lowrate,
    // system path results
    output logic [2:0] sys_damping_factor,
    output logic sys_analog_feedback,
    output logic sys_pd2_active,
    output logic [2:0] sys_pd2_gain,
    // auxiliary path results
    output logic [2:0] aux_damping_factor,
    output logic aux_analog_feedback,
    output logic aux_pd2_active,
    output logic [2:0] aux_pd2_gain
);
    logic [7:0] aux_gd_q, aux_gd_d;
    logic [7:0] sys_gd_q, sys_gd_d;
    logic [7:0] aux_pg_q, aux_pg_d;
    logic [7:0] sys_pg_q, sys_pg_d;
    logic [7:0] rdata_q, rdata_d;
    logic [2:0] sys_df_q, sys_df_d, aux_df_q, aux_df_d;
    logic [2:0] sys_gain_q, sys_gain_d, aux_gain_q, aux_gain_d;
    logic sys_an_q, sys_an_d, aux_an_q, aux_an_d;
    logic sys_act_q, sys_act_d, aux_act_q, aux_act_d;
    logic [4:0] sys_bw_code;
    dlgdc_bw_t sys_bw, aux_bw;
    logic sys_analog;

    dlgdc_path_if sys_p ();
    dlgdc_path_if aux_p ();

    dlgdc_damping u_sys_damping_code (.p(sys_p.dmp));
    dlgdc_damping u_aux_damping_code (.p(aux_p.dmp));
    dlgdc_gain u_sys_gain (.p(sys_p.gan));
    dlgdc_gain u_aux_gain (.p(aux_p.gan));

    // register writes and reads
    always_comb begin
        aux_gd_d = aux_gd_q;
        sys_gd_d = sys_gd_q;
        aux_pg_d = aux_pg_q;
        sys_pg_d = sys_pg_q;
        rdata_d = rdata_q;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_AUX_GAIN_DAMPING:
                    aux_gd_d = reg_wdata & MASK_GAIN_DAMPING;
                ADDR_SYS_GAIN_DAMPING:
                    sys_gd_d = reg_wdata & MASK_GAIN_DAMPING;
                ADDR_AUX_PD_GAIN: aux_pg_d = reg_wdata & MASK_PD_GAIN;
                ADDR_SYS_PD_GAIN: sys_pg_d = reg_wdata & MASK_PD_GAIN;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_AUX_GAIN_DAMPING: rdata_d = aux_gd_q;
                ADDR_SYS_GAIN_DAMPING: rdata_d = sys_gd_q;
                ADDR_AUX_PD_GAIN: rdata_d = aux_pg_q;
                ADDR_SYS_PD_GAIN: rdata_d = sys_pg_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aux_gd_q <= RST_GAIN_DAMPING;
            sys_gd_q <= RST_GAIN_DAMPING;
            aux_pg_q <= RST_PD_GAIN;
            sys_pg_q <= RST_PD_GAIN;
            rdata_q <= 8'h00;
        end else begin
            aux_gd_q <= aux_gd_d;
            sys_gd_q <= sys_gd_d;
            aux_pg_q <= aux_pg_d;
            sys_pg_q <= sys_pg_d;
            rdata_q <= rdata_d;
        end
    end

    // bandwidth columns and feedback modes
    always_comb begin
        sys_bw_code = system_acquire_active ? system_acquire_bandwidth
            : system_locked_bandwidth;
        if (sys_bw_code <= SYS_BW_4HZ) begin
            sys_bw = BW_LE4;
        end else if (sys_bw_code == SYS_BW_8HZ) begin
            sys_bw = BW_8;
        end else if (sys_bw_code == SYS_BW_18HZ) begin
            sys_bw = BW_18;
        end else if (sys_bw_code == SYS_BW_35HZ) begin
            sys_bw = BW_35;
        end else begin
            sys_bw = BW_70;
        end
        case (aux_loop_bandwidth)
            AUX_BW_35HZ: aux_bw = BW_35;
            AUX_BW_70HZ: aux_bw = BW_70;
            default: aux_bw = BW_18;
        endcase
        sys_analog = (system_output_freq_select == SYS_FREQ_ANALOG);
    end

    // system and auxiliary path bundles
    assign sys_p.damping_code_code = sys_gd_q[DAMPING_CODE_LSB +: FIELD_W];
    assign sys_p.bw = sys_bw;
    assign sys_p.pd2_en = sys_pg_q[EN_BIT];
    assign sys_p.analog = sys_analog;
    assign sys_p.lowrate = system_input_lowrate;
    assign sys_p.ga8k = sys_gd_q[GA8K_LSB +: FIELD_W];
    assign sys_p.ga = sys_pg_q[GA_LSB +: FIELD_W];
    assign sys_p.gd = sys_pg_q[GD_LSB +: FIELD_W];
    assign aux_p.analog = !aux_digital_feedback_select;
    assign aux_p.damping_code_code = aux_gd_q[DAMPING_CODE_LSB +: FIELD_W];
    assign aux_p.bw = aux_bw;
    assign aux_p.pd2_en = aux_pg_q[EN_BIT];
    assign aux_p.lowrate = aux_input_lowrate;
    assign aux_p.ga8k = aux_gd_q[GA8K_LSB +: FIELD_W];
    assign aux_p.ga = aux_pg_q[GA_LSB +: FIELD_W];
    assign aux_p.gd = aux_pg_q[GD_LSB +: FIELD_W];

    // registered results
    always_comb begin
        sys_df_d = sys_p.damping_code;
        aux_df_d = aux_p.damping_code;
        sys_gain_d = sys_p.gain;
        aux_gain_d = aux_p.gain;
        sys_act_d = sys_p.active;
        aux_act_d = aux_p.active;
        sys_an_d = sys_p.analog;
        aux_an_d = aux_p.analog;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sys_df_q <= DF_5;
            aux_df_q <= DF_5;
            sys_gain_q <= GAIN_OFF;
            aux_gain_q <= GAIN_OFF;
            sys_act_q <= 1'b0;
            aux_act_q <= 1'b0;
            sys_an_q <= 1'b0;
            aux_an_q <= 1'b0;
        end else begin
            sys_df_q <= sys_df_d;
            aux_df_q <= aux_df_d;
            sys_gain_q <= sys_gain_d;
            aux_gain_q <= aux_gain_d;
            sys_act_q <= sys_act_d;
            aux_act_q <= aux_act_d;
            sys_an_q <= sys_an_d;
            aux_an_q <= aux_an_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign sys_damping_factor = sys_df_q;
    assign aux_damping_factor = aux_df_q;
    assign sys_pd2_gain = sys_gain_q;
    assign aux_pd2_gain = aux_gain_q;
    assign sys_pd2_active = sys_act_q;
    assign aux_pd2_active = aux_act_q;
    assign sys_analog_feedback = sys_an_q;
    assign aux_analog_feedback = aux_an_q;

    // checks
    sequence s_sys_wr_damp5;
        nrst && reg_wr && reg_addr == ADDR_SYS_GAIN_DAMPING
            && reg_wdata[DAMPING_CODE_LSB +: FIELD_W] == DAMPING_CODE_CODE_5;
    endsequence

    sequence s_sys_bw70_hold;
        (!system_acquire_active && system_locked_bandwidth == SYS_BW_70HZ
            && !reg_wr) [*2];
    endsequence

    property p_aux_default_damping_code;
        @(posedge clock) disable iff (!nrst)
        aux_gd_q[DAMPING_CODE_LSB +: FIELD_W] == DAMPING_CODE_CODE_3
            |=> aux_damping_factor == DF_5;
    endproperty
    a_aux_default_damping_code: assert property (p_aux_default_damping_code)
        else $error("aux damping code 011 did not give 5");

    property p_aux_damp20;
        @(posedge clock) disable iff (!nrst)
        nrst && aux_gd_q[DAMPING_CODE_LSB +: FIELD_W] == DAMPING_CODE_CODE_5
            && aux_loop_bandwidth == AUX_BW_70HZ
            |=> aux_damping_factor == DF_20;
    endproperty
    a_aux_damp20: assert property (p_aux_damp20)
        else $error("aux code 101 at 70hz did not give 20");

    property p_aux_bw35;
        @(posedge clock) disable iff (!nrst)
        nrst && aux_gd_q[DAMPING_CODE_LSB +: FIELD_W] == DAMPING_CODE_CODE_4
            && aux_loop_bandwidth == AUX_BW_35HZ
            |=> aux_damping_factor == DF_10;
    endproperty
    a_aux_bw35: assert property (p_aux_bw35)
        else $error("aux 35hz column not selected");

    property p_sys_acq_bw;
        @(posedge clock) disable iff (!nrst)
        system_acquire_active && system_acquire_bandwidth == SYS_BW_70HZ
            && system_locked_bandwidth == SYS_BW_4HZ && nrst
            && sys_gd_q[DAMPING_CODE_LSB +: FIELD_W] == DAMPING_CODE_CODE_5
            |=> sys_damping_factor == DF_20;
    endproperty
    a_sys_acq_bw: assert property (p_sys_acq_bw)
        else $error("acquisition bandwidth not used for damping");

    property p_sys_low_bw;
        @(posedge clock) disable iff (!nrst)
        !system_acquire_active && system_locked_bandwidth <= SYS_BW_4HZ
            |=> sys_damping_factor == DF_5;
    endproperty
    a_sys_low_bw: assert property (p_sys_low_bw)
        else $error("sys damping not 5 at 4hz or below");

    property p_sys_wr_damping_code;
        @(posedge clock) disable iff (!nrst)
        s_sys_wr_damp5 ##1 s_sys_bw70_hold |=> sys_damping_factor == DF_20;
    endproperty
    a_sys_wr_damping_code: assert property (p_sys_wr_damping_code)
        else $error("written sys code 101 at 70hz did not give 20");

    property p_unused_code;
        @(posedge clock) disable iff (!nrst)
        sys_gd_q[DAMPING_CODE_LSB +: FIELD_W] == 3'h0 |=> sys_damping_factor == DF_5;
    endproperty
    a_unused_code: assert property (p_unused_code)
        else $error("unused damping code not treated as default");

    property p_sys_mode;
        @(posedge clock) disable iff (!nrst)
        nrst |=> sys_analog_feedback
            == ($past(system_output_freq_select) == SYS_FREQ_ANALOG);
    endproperty
    a_sys_mode: assert property (p_sys_mode)
        else $error("sys feedback mode wrong for frequency select");

    property p_aux_mode;
        @(posedge clock) disable iff (!nrst)
        nrst && $rose(aux_digital_feedback_select) |=> !aux_analog_feedback;
    endproperty
    a_aux_mode: assert property (p_aux_mode)
        else $error("aux feedback mode not taken from its bit");

    property p_disabled;
        @(posedge clock) disable iff (!nrst)
        !sys_pg_q[EN_BIT] |=> !sys_pd2_active && sys_pd2_gain == GAIN_OFF;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("sys gain used while detector disabled");

    property p_sys_lowrate;
        @(posedge clock) disable iff (!nrst)
        nrst && sys_pg_q[EN_BIT] && sys_analog && system_input_lowrate
            |=> sys_pd2_gain == $past(sys_gd_q[GA8K_LSB +: FIELD_W]);
    endproperty
    a_sys_lowrate: assert property (p_sys_lowrate)
        else $error("sys low-rate analog gain not applied");

    property p_sys_digital;
        @(posedge clock) disable iff (!nrst)
        nrst && sys_pg_q[EN_BIT] && !sys_analog
            |=> sys_pd2_active
            && sys_pd2_gain == $past(sys_pg_q[GD_LSB +: FIELD_W]);
    endproperty
    a_sys_digital: assert property (p_sys_digital)
        else $error("sys digital gain not applied");

    property p_aux_analog;
        @(posedge clock) disable iff (!nrst)
        nrst && aux_pg_q[EN_BIT] && !aux_digital_feedback_select
            && !aux_input_lowrate
            |=> aux_pd2_gain == $past(aux_pg_q[GA_LSB +: FIELD_W]);
    endproperty
    a_aux_analog: assert property (p_aux_analog)
        else $error("aux analog gain not applied above 8khz");

    property p_aux_digital;
        @(posedge clock) disable iff (!nrst)
        nrst && aux_pg_q[EN_BIT] && aux_digital_feedback_select
            |=> aux_pd2_active
            && aux_pd2_gain == $past(aux_pg_q[GD_LSB +: FIELD_W]);
    endproperty
    a_aux_digital: assert property (p_aux_digital)
        else $error("aux digital gain not applied");
endmodule

// ==== dlgdc_testbench.sv ====
// self-checking bench for the dpll gain and damping register bank
`timescale 1ns/1ps
module testbench;
    import dlgdc_pkg::*;
    typedef struct packed {
        logic [2:0] code;
        logic [0:4][2:0] s;
        logic [0:2][2:0] a;
    } dlgdc_drow_t;
    typedef struct packed {
        logic en;
        logic analog;
        logic low;
        logic [2:0] gain;
    } dlgdc_grow_t;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] aux_loop_bandwidth = 2'h0;
    logic [4:0] system_acquire_bandwidth = 5'h0f;
    logic [4:0] system_locked_bandwidth = 5'h0b;
    logic system_acquire_active = 1'b0;
    logic [2:0] system_output_freq_select = 3'h0;
    logic aux_digital_feedback_select = 1'b1;
    logic system_input_lowrate = 1'b0;
    logic aux_input_lowrate = 1'b0;
    logic [2:0] sys_damping_factor;
    logic sys_analog_feedback;
    logic sys_pd2_active;
    logic [2:0] sys_pd2_gain;
    logic [2:0] aux_damping_factor;
    logic aux_analog_feedback;
    logic aux_pd2_active;
    logic [2:0] aux_pd2_gain;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    dlgdc_drow_t drows[8];
    dlgdc_grow_t grows[8];
    logic [4:0] sys_bw[5];
    logic [1:0] aux_bw[3];
    logic [7:0] addrs[4];
    logic [7:0] masks[4];

    dlgdc_bank DUT (
        .clock(clock),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .aux_loop_bandwidth(aux_loop_bandwidth),
        .system_acquire_bandwidth(system_acquire_bandwidth),
        .system_locked_bandwidth(system_locked_bandwidth),
        .system_acquire_active(system_acquire_active),
        .system_output_freq_select(system_output_freq_select),
        .aux_digital_feedback_select(aux_digital_feedback_select),
        .system_input_lowrate(system_input_lowrate),
        .aux_input_lowrate(aux_input_lowrate),
        .sys_damping_factor(sys_damping_factor),
        .sys_analog_feedback(sys_analog_feedback),
        .sys_pd2_active(sys_pd2_active),
        .sys_pd2_gain(sys_pd2_gain),
        .aux_damping_factor(aux_damping_factor),
        .aux_analog_feedback(aux_analog_feedback),
        .aux_pd2_active(aux_pd2_active),
        .aux_pd2_gain(aux_pd2_gain)
    );

    always #10 clock = ~clock;

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            $display("Error at %0t: run did not finish", $time);
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
        input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: %s seen %h expected %h", $time, what,
                seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        #1;
        check(reg_rdata, exp, "read data");
    endtask

    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    initial begin
        drows[0] = {3'h1, DF_5, DF_2P5, DF_1P2, DF_1P2, DF_1P2,
            DF_1P2, DF_1P2, DF_1P2};
        drows[1] = {3'h2, DF_5, DF_5, DF_2P5, DF_2P5, DF_2P5,
            DF_2P5, DF_2P5, DF_2P5};
        drows[2] = {3'h3, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5};
        drows[3] = {3'h4, DF_5, DF_5, DF_5, DF_10, DF_10, DF_5, DF_10, DF_10};
        drows[4] = {3'h5, DF_5, DF_5, DF_5, DF_10, DF_20, DF_5, DF_10, DF_20};
        drows[5] = {3'h0, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5};
        drows[6] = {3'h6, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5};
        drows[7] = {3'h7, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5, DF_5};
        // enable, analog, low rate, then gain picked from 5/6/3 fields
        grows[0] = {3'b000, 3'h0};
        grows[1] = {3'b001, 3'h0};
        grows[2] = {3'b010, 3'h0};
        grows[3] = {3'b011, 3'h0};
        grows[4] = {3'b100, 3'h6};
        grows[5] = {3'b101, 3'h6};
        grows[6] = {3'b110, 3'h5};
        grows[7] = {3'b111, 3'h3};
        sys_bw = '{SYS_BW_4HZ, SYS_BW_8HZ, SYS_BW_18HZ, SYS_BW_35HZ,
            SYS_BW_70HZ};
        aux_bw = '{AUX_BW_18HZ, AUX_BW_35HZ, AUX_BW_70HZ};
        addrs = '{ADDR_AUX_GAIN_DAMPING, ADDR_SYS_GAIN_DAMPING,
            ADDR_AUX_PD_GAIN, ADDR_SYS_PD_GAIN};
        masks = '{8'h77, 8'h77, 8'hf7, 8'hf7};
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        settle();
        check(sys_damping_factor, DF_5, "sys damping");
        check(aux_damping_factor, DF_5, "aux damping");
        check(sys_pd2_active, 1'b1, "sys enable");
        check(aux_pd2_active, 1'b1, "aux enable");
        check(sys_pd2_gain, 3'h2, "sys gain");
        check(aux_pd2_gain, 3'h2, "aux gain");
        rd(ADDR_SYS_GAIN_DAMPING, 8'h13);
        rd(ADDR_AUX_PD_GAIN, 8'hc2);
        rd(ADDR_SYS_PD_GAIN, 8'hc2);
        rd(ADDR_AUX_GAIN_DAMPING, 8'h13);
        $display("test reset values done");
        foreach (drows[i]) begin
            wr(ADDR_SYS_GAIN_DAMPING, {5'h02, drows[i].code});
            wr(ADDR_AUX_GAIN_DAMPING, {5'h02, drows[i].code});
            for (int c = 0; c < 5; c++) begin
                @(posedge clock);
                system_locked_bandwidth <= sys_bw[c];
                aux_loop_bandwidth <= aux_bw[c % 3];
                settle();
                check(sys_damping_factor, drows[i].s[c], "sys df");
                check(aux_damping_factor, drows[i].a[c % 3], "aux");
            end
        end
        $display("test damping table done");
        // default code 011 while gains are probed
        wr(ADDR_SYS_GAIN_DAMPING, 8'h33);
        wr(ADDR_AUX_GAIN_DAMPING, 8'h33);
        foreach (grows[i]) begin
            wr(ADDR_SYS_PD_GAIN, {grows[i].en, 7'h56});
            wr(ADDR_AUX_PD_GAIN, {grows[i].en, 7'h56});
            @(posedge clock);
            system_output_freq_select <= grows[i].analog ? SYS_FREQ_ANALOG :
                SYS_FREQ_DIGITAL;
            aux_digital_feedback_select <= ~grows[i].analog;
            system_input_lowrate <= grows[i].low;
            aux_input_lowrate <= grows[i].low;
            settle();
            check(sys_pd2_gain, grows[i].gain, "sys gain");
            check(aux_pd2_gain, grows[i].gain, "aux gain");
            check(sys_pd2_active, grows[i].en, "sys enable");
            check(aux_pd2_active, grows[i].en, "aux enable");
            check(sys_analog_feedback, grows[i].analog, "sys mode");
            check(aux_analog_feedback, grows[i].analog, "aux mode");
        end
        $display("test gain selection done");
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            system_output_freq_select <= k[2:0];
            system_input_lowrate <= 1'b0;
            settle();
            check(sys_analog_feedback, k == 1, "sys mode");
            check(sys_pd2_gain, (k == 1) ? 3'h5 : 3'h6, "sys gain");
        end
        $display("test frequency select done");
        wr(ADDR_SYS_GAIN_DAMPING, 8'h05);
        settle();
        check(sys_damping_factor, DF_20, "written code at 70hz");
        @(posedge clock);
        system_locked_bandwidth <= SYS_BW_4HZ;
        system_acquire_bandwidth <= SYS_BW_70HZ;
        system_acquire_active <= 1'b0;
        settle();
        check(sys_damping_factor, DF_5, "locked column");
        @(posedge clock);
        system_acquire_active <= 1'b1;
        settle();
        check(sys_damping_factor, DF_20, "acquire column");
        $display("test bandwidth in effect done");
        foreach (addrs[i]) begin
            wr(addrs[i], 8'hff);
            rd(addrs[i], masks[i]);
        end
        wr(8'h6e, 8'h5a);
        rd(8'h6e, 8'h00);
        rd(ADDR_SYS_PD_GAIN, 8'hf7);
        $display("test reserved bits done");
        @(posedge clock);
        nrst <= 1'b0;
        settle();
        check(sys_pd2_gain, GAIN_OFF, "gain in reset");
        check(aux_damping_factor, DF_5, "damping in reset");
        @(posedge clock);
        nrst <= 1'b1;
        rd(ADDR_SYS_GAIN_DAMPING, 8'h13);
        rd(ADDR_AUX_PD_GAIN, 8'hc2);
        $display("test second reset done");
        conclude();
    end
endmodule
